// ===== hw/gauge_pkg.sv
// Package: constants and carriers for the coulomb counting measurement core
// Operation
// - One voltage and temperature sample every one-second period; current updates on each accepted sense sample.
// - Sense input a above b counts charge; below counts discharge.
// - Integration counter accumulates sense signal; one step is 2.6 nVh.
// - Each second fold the integration counter into remaining capacity.
// - Both SMBus lines low for 20 s starts offset autocalibration.
// - Counts below the digital filter threshold (config 0x2B) are dropped.
// - Select each cell on the front end, measure, report unscaled at 0x3C-0x3F.
// - Config 0x2A bit 7 set uses internal sensor, clear uses thermistor.
// - Compensate charge for temperature and charge state; adjust self-discharge.
// - Remaining capacity adjusted for charge and compensation, and for self-discharge only in periods that fold a discharge; readable.
// - Full-charge capacity updates only after a qualified full discharge.
// - Hidden discharge tracking count is the source of capacity updates.
// - Remaining capacity clamps between zero and full-charge capacity.
package gauge_pkg;

   // ------------------------------------------------------------------
   // Register locations
   // ------------------------------------------------------------------
   localparam logic [7:0] CFG_MISC_ADDR    = 8'h2A;
   localparam logic [7:0] CFG_FILTER_ADDR  = 8'h2B;
   localparam logic [7:0] CELL_ONE_ADDR    = 8'h3C;
   localparam logic [7:0] CELL_TWO_ADDR    = 8'h3D;
   localparam logic [7:0] CELL_THREE_ADDR  = 8'h3E;
   localparam logic [7:0] CELL_FOUR_ADDR   = 8'h3F;
   localparam logic [7:0] TS_CONST_FIRST   = 8'hA4;
   localparam logic [7:0] TS_CONST_LAST    = 8'hAD;
   localparam logic [7:0] VOLTAGE_ADDR     = 8'h09;
   localparam logic [7:0] CURRENT_ADDR     = 8'h0A;
   localparam logic [7:0] TEMP_ADDR        = 8'h08;
   localparam logic [7:0] REM_CAP_ADDR     = 8'h0F;
   localparam logic [7:0] FULL_CAP_ADDR    = 8'h10;
   localparam int         MISC_IT_BIT      = 7;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_MHZ          = 250;
   localparam int PERIOD_MS        = 1000;
   localparam int CAL_IDLE_S       = 20;
   localparam int PERIOD_CYCLES    = PERIOD_MS * 1000 * CLK_MHZ;
   localparam longint CAL_CYCLES   = longint'(CAL_IDLE_S) * 1000000 * CLK_MHZ;
   localparam int CAL_LEN_CYCLES   = 64;

   // ------------------------------------------------------------------
   // Integration and reset values
   // ------------------------------------------------------------------
   localparam int STEP_PVH         = 2600;   // 2.6 nVh per integrator step
   localparam int UNIT_SHIFT       = 10;     // log2 of integrator steps per capacity unit (1024 steps)
   localparam logic [15:0] FCC_RESET    = 16'h1000;
   localparam logic [15:0] FILTER_RESET = 16'h0004;
   localparam logic [15:0] NEAR_FULL    = 16'h0040;
   localparam logic [15:0] LOW_LEVEL    = 16'h0100;
   localparam int NUM_CELLS        = 4;

   typedef enum logic [1:0] {
      MEAS_IDLE,
      MEAS_CELL,
      MEAS_TEMP,
      MEAS_FOLD
   } meas_state_e;

   typedef struct packed {
      logic [7:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_s;

endpackage : gauge_pkg

// ===== hw/coulomb_counter.sv
// Coulomb counting measurement core with its register window
`timescale 1ns/10ps
module coulomb_counter #(
   parameter int     PERIOD_CNT = gauge_pkg::PERIOD_CYCLES,
   parameter longint CAL_CNT    = gauge_pkg::CAL_CYCLES
) (
   input  wire logic                 clk,            // 250 MHz clock
   input  wire logic                 rstn,           // Async reset, low
   input  wire logic signed [15:0]   sense_sample,   // Sense input a minus b
   input  wire logic                 sense_valid,    // Sense sample strobe
   input  wire logic [15:0]          cell_voltage_input, // Cell ADC value
   input  wire logic [15:0]          thermistor_input,   // External temp ADC
   input  wire logic [15:0]          internal_temp,  // Internal sensor ADC
   input  wire logic                 smb_clk_in,     // SMBus clock level
   input  wire logic                 smb_data_in,    // SMBus data level
   input  wire gauge_pkg::reg_req_s  req,            // Register request
   output logic [15:0]               rdata,          // Read data
   output logic                      rvalid,         // Read data strobe
   output logic [1:0]                cell_select,    // Front-end cell mux
   output logic                      sample_strobe,  // Period sample pulse
   output logic                      calibrating,    // Offset cal running
   output logic                      internal_sensor_select // Sensor choice
);
   import gauge_pkg::*;

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function automatic logic [15:0] sat_add(input logic [15:0] a,
                                           input logic [15:0] b,
                                           input logic [15:0] lim);
      logic [16:0] s;
      s = {1'b0, a} + {1'b0, b};
      sat_add = (s > {1'b0, lim}) ? lim : s[15:0];
   endfunction : sat_add

   function automatic logic [15:0] sat_sub(input logic [15:0] a,
                                           input logic [15:0] b);
      sat_sub = (b > a) ? 16'h0000 : a - b;
   endfunction : sat_sub

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   meas_state_e        state_reg, state_next;
   logic [31:0]        tick_reg, tick_next;
   logic [35:0]        idle_reg, idle_next;
   logic [6:0]         cal_reg, cal_next;
   logic signed [15:0] offset_reg, offset_next;
   logic signed [31:0] integ_reg, integ_next;
   logic [15:0]        rem_reg, rem_next;
   logic [15:0]        fcc_reg, fcc_next;
   logic [15:0]        dtc_reg, dtc_next;
   logic               track_reg, track_next;
   logic [15:0]        misc_reg, misc_next;
   logic [15:0]        filt_reg, filt_next;
   logic [15:0]        volt_reg, volt_next;
   logic [15:0]        curr_reg, curr_next;
   logic [15:0]        temp_reg, temp_next;
   logic [15:0]        cells_reg [NUM_CELLS];
   logic [15:0]        cells_next [NUM_CELLS];
   logic [1:0]         sel_reg, sel_next;
   logic [15:0]        rdata_reg, rdata_next;
   logic               rvalid_reg, rvalid_next;
   logic               strobe_reg, strobe_next;

   logic signed [15:0] corr;
   logic [15:0]        mag;
   logic signed [31:0] whole;
   logic [15:0]        units;
   logic [15:0]        tsel;
   logic [15:0]        selfdis;

   // ------------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------------
   always_comb begin
      state_next  = state_reg;
      tick_next   = tick_reg + 32'h1;
      idle_next   = idle_reg;
      cal_next    = cal_reg;
      offset_next = offset_reg;
      integ_next  = integ_reg;
      rem_next    = rem_reg;
      fcc_next    = fcc_reg;
      dtc_next    = dtc_reg;
      track_next  = track_reg;
      misc_next   = misc_reg;
      filt_next   = filt_reg;
      volt_next   = volt_reg;
      curr_next   = curr_reg;
      temp_next   = temp_reg;
      cells_next  = cells_reg;
      sel_next    = sel_reg;
      rdata_next  = rdata_reg;
      rvalid_next = 1'b0;
      strobe_next = 1'b0;
      corr        = sense_sample - offset_reg;
      mag         = corr[15] ? 16'(-corr) : corr;
      whole       = integ_reg >>> UNIT_SHIFT;
      units       = whole[31] ? 16'(-whole) : whole[15:0];
      tsel        = misc_reg[MISC_IT_BIT] ? internal_temp
                                          : thermistor_input;
      // Warmer packs lose charge faster; crude one-unit-per-step estimate
      selfdis     = {12'h000, temp_reg[15:12]};

      // Idle SMBus timer; a single high level restarts the 20 s wait
      if (smb_clk_in || smb_data_in) begin
         idle_next = '0;
      end else if (idle_reg < 36'(CAL_CNT)) begin
         idle_next = idle_reg + 36'h1;
      end
      if (cal_reg != 7'h00) begin
         cal_next = cal_reg - 7'h01;
         if (sense_valid) begin
            offset_next = sense_sample;
         end
      end else if (idle_reg == 36'(CAL_CNT) - 36'h1) begin
         cal_next = 7'(CAL_LEN_CYCLES);
      end

      // Integrator: positive difference is charge, negative discharge
      if (sense_valid && cal_reg == 7'h00 && mag >= filt_reg) begin
         integ_next = integ_reg + 32'(corr);
         curr_next  = corr;
      end

      case (state_reg)
         MEAS_IDLE: begin
            if (tick_reg >= PERIOD_CNT - 1) begin
               tick_next   = '0;
               strobe_next = 1'b1;
               sel_next    = '0;
               state_next  = MEAS_CELL;
            end
         end
         MEAS_CELL: begin
            // Front end routes cell sel_reg; one cycle of settle per cell
            cells_next[sel_reg] = cell_voltage_input;
            if (sel_reg == 2'(NUM_CELLS - 1)) begin
               // Park the mux on cell one so the select never dwells high
               sel_next   = '0;
               state_next = MEAS_TEMP;
            end else begin
               sel_next = sel_reg + 2'h1;
            end
         end
         MEAS_TEMP: begin
            temp_next  = tsel;
            volt_next  = cells_reg[0] + cells_reg[1] + cells_reg[2]
                       + cells_reg[3];
            state_next = MEAS_FOLD;
         end
         MEAS_FOLD: begin
            // Residue below one unit is kept for the next period
            integ_next = integ_reg - (whole <<< UNIT_SHIFT);
            if (!whole[31]) begin
               // Charge efficiency trimmed when hot or near full
               rem_next = sat_add(rem_reg,
                  units - ((temp_reg[15] || rem_reg > fcc_reg - NEAR_FULL)
                           ? (units >> 3) : 16'h0000),
                  fcc_reg);
               if (units != 16'h0000) begin
                  track_next = 1'b0;
               end
            end else begin
               rem_next = sat_sub(sat_sub(rem_reg, units), selfdis);
               if (rem_reg >= fcc_reg - NEAR_FULL && !track_reg) begin
                  track_next = 1'b1;
                  dtc_next   = fcc_reg - rem_reg;
               end else if (track_reg) begin
                  dtc_next = dtc_reg + units + selfdis;
               end
               if (track_reg && rem_reg <= LOW_LEVEL) begin
                  fcc_next   = dtc_reg + LOW_LEVEL;
                  track_next = 1'b0;
               end
            end
            state_next = MEAS_IDLE;
         end
         default: state_next = MEAS_IDLE;
      endcase
      if (state_reg == MEAS_FOLD && whole[31]) begin
         rem_next = sat_sub(rem_next, 16'h0000);
      end

      // Register window
      if (req.wr) begin
         case (req.addr)
            CFG_MISC_ADDR:   misc_next = req.wdata;
            CFG_FILTER_ADDR: filt_next = req.wdata;
            default: ;
         endcase
      end
      if (req.rd) begin
         rvalid_next = 1'b1;
         case (req.addr)
            CFG_MISC_ADDR:   rdata_next = misc_reg;
            CFG_FILTER_ADDR: rdata_next = filt_reg;
            CELL_ONE_ADDR:   rdata_next = cells_reg[0];
            CELL_TWO_ADDR:   rdata_next = cells_reg[1];
            CELL_THREE_ADDR: rdata_next = cells_reg[2];
            CELL_FOUR_ADDR:  rdata_next = cells_reg[3];
            VOLTAGE_ADDR:    rdata_next = volt_reg;
            CURRENT_ADDR:    rdata_next = curr_reg;
            TEMP_ADDR:       rdata_next = temp_reg;
            REM_CAP_ADDR:    rdata_next = rem_reg;
            FULL_CAP_ADDR:   rdata_next = fcc_reg;
            default:         rdata_next = 16'h0000;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg  <= MEAS_IDLE;
         tick_reg   <= '0;
         idle_reg   <= '0;
         cal_reg    <= '0;
         offset_reg <= '0;
         integ_reg  <= '0;
         rem_reg    <= '0;
         fcc_reg    <= FCC_RESET;
         dtc_reg    <= '0;
         track_reg  <= 1'b0;
         misc_reg   <= '0;
         filt_reg   <= FILTER_RESET;
         volt_reg   <= '0;
         curr_reg   <= '0;
         temp_reg   <= '0;
         for (int i = 0; i < NUM_CELLS; i++) begin
            cells_reg[i] <= '0;
         end
         sel_reg    <= '0;
         rdata_reg  <= '0;
         rvalid_reg <= 1'b0;
         strobe_reg <= 1'b0;
      end else begin
         state_reg  <= state_next;
         tick_reg   <= tick_next;
         idle_reg   <= idle_next;
         cal_reg    <= cal_next;
         offset_reg <= offset_next;
         integ_reg  <= integ_next;
         rem_reg    <= rem_next;
         fcc_reg    <= fcc_next;
         dtc_reg    <= dtc_next;
         track_reg  <= track_next;
         misc_reg   <= misc_next;
         filt_reg   <= filt_next;
         volt_reg   <= volt_next;
         curr_reg   <= curr_next;
         temp_reg   <= temp_next;
         cells_reg  <= cells_next;
         sel_reg    <= sel_next;
         rdata_reg  <= rdata_next;
         rvalid_reg <= rvalid_next;
         strobe_reg <= strobe_next;
      end
   end

   assign rdata                  = rdata_reg;
   assign rvalid                 = rvalid_reg;
   assign cell_select            = sel_reg;
   assign sample_strobe          = strobe_reg;
   assign calibrating            = (cal_reg != 7'h00);
   assign internal_sensor_select = misc_reg[MISC_IT_BIT];

endmodule : coulomb_counter

// ===== sim/coulomb_counter_sva.sv
// Port checker for the coulomb counting core
`timescale 1ns/10ps
module coulomb_counter_sva #(
   parameter int     PERIOD_CNT = 200,
   parameter longint CAL_CNT    = 50
) (
   input wire logic                clk,
   input wire logic                rstn,
   input wire logic                smb_clk_in,
   input wire logic                smb_data_in,
   input wire gauge_pkg::reg_req_s req,
   input wire logic [15:0]         rdata,
   input wire logic                rvalid,
   input wire logic [1:0]          cell_select,
   input wire logic                sample_strobe,
   input wire logic                calibrating,
   input wire logic                internal_sensor_select
);
   import gauge_pkg::*;
   longint idle_cnt;
   int     gap_cnt;
   int     cal_len;
   logic   seen;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // ----------------------------------------------------------
   // Helper counters
   // ----------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         idle_cnt <= 0;
         gap_cnt  <= 0;
         cal_len  <= 0;
         seen     <= 1'b0;
      end else begin
         idle_cnt <= (smb_clk_in || smb_data_in) ? 0 : idle_cnt + 1;
         gap_cnt  <= sample_strobe ? 1 : gap_cnt + 1;
         cal_len  <= calibrating ? cal_len + 1 : 0;
         seen     <= seen || sample_strobe;
      end
   end
   chk_read_answer: assert property (req.rd |=> rvalid)
      else $error("read not answered next cycle");
   chk_no_spurious: assert property (!req.rd |=> !rvalid)
      else $error("read strobe without request");
   chk_unmapped_zero: assert property
      (req.rd && req.addr == 8'h55 |=> rdata == 16'h0000)
      else $error("unmapped read not zero");
   chk_misc_write: assert property (req.wr && req.addr == CFG_MISC_ADDR
      |=> internal_sensor_select == $past(req.wdata[MISC_IT_BIT]))
      else $error("sensor select not taken from write");
   chk_misc_read: assert property (req.rd && !req.wr
      && req.addr == CFG_MISC_ADDR
      |=> rdata[MISC_IT_BIT] == internal_sensor_select)
      else $error("sensor select readback differs");
   chk_strobe_pulse: assert property (sample_strobe |=> !sample_strobe)
      else $error("period strobe longer than a cycle");
   chk_period_gap: assert property (sample_strobe && seen
      |-> gap_cnt inside {[PERIOD_CNT - 1:PERIOD_CNT + 1]})
      else $error("period length wrong");
   chk_cell_step: assert property ($changed(cell_select)
      |-> cell_select == $past(cell_select) + 2'd1)
      else $error("cell select out of order");
   chk_cell_dwell: assert property (cell_select != 2'd0
      |=> $changed(cell_select))
      else $error("cell select held too long");
   chk_cal_idle: assert property ($rose(calibrating)
      |-> idle_cnt >= CAL_CNT - 1)
      else $error("calibration without idle bus");
   chk_cal_length: assert property (calibrating
      |-> cal_len <= CAL_LEN_CYCLES)
      else $error("calibration too long");
endmodule : coulomb_counter_sva

bind coulomb_counter coulomb_counter_sva #(
   .PERIOD_CNT(PERIOD_CNT),
   .CAL_CNT   (CAL_CNT)
) u_sva (
   .clk(clk), .rstn(rstn), .smb_clk_in(smb_clk_in),
   .smb_data_in(smb_data_in), .req(req), .rdata(rdata),
   .rvalid(rvalid), .cell_select(cell_select),
   .sample_strobe(sample_strobe), .calibrating(calibrating),
   .internal_sensor_select(internal_sensor_select)
);

// ===== sim/frontend_model.sv
// Analog front-end model routing the selected cell to its output
`timescale 1ns/10ps
module frontend_model (
   input  wire logic [1:0]       cell_select,         // Cell mux select
   input  wire logic [3:0][15:0] cells,               // Cell voltages
   output logic      [15:0]      frontend_cell_output // Routed cell
);
   // Mux is combinational, so a late select shows the wrong cell
   assign frontend_cell_output = cells[cell_select];
endmodule : frontend_model

// ===== sim/coulomb_counter_tb.sv
// Self-checking bench for the coulomb counting core
`timescale 1ns/10ps
module coulomb_counter_tb;
   import gauge_pkg::*;
   localparam int     PER = 200;
   localparam longint CAL = 50;
   logic               clk, rstn, sense_valid, smb_clk_in, smb_data_in;
   logic signed [15:0] sense_sample;
   logic [15:0]        cell_voltage_input, thermistor_input, internal_temp;
   logic [15:0]        rdata, rd_val, sum;
   logic [3:0][15:0]   cells;
   logic               rvalid, sample_strobe, calibrating, internal_sensor_select;
   logic [1:0]         cell_select;
   reg_req_s           req;
   int                 err_count, comparisons, acc, rem_m, units, filt, i;
   integer             seed;
   coulomb_counter #(.PERIOD_CNT(PER), .CAL_CNT(CAL)) dut (
      .clk(clk), .rstn(rstn), .sense_sample(sense_sample),
      .sense_valid(sense_valid), .cell_voltage_input(cell_voltage_input),
      .thermistor_input(thermistor_input), .internal_temp(internal_temp),
      .smb_clk_in(smb_clk_in), .smb_data_in(smb_data_in), .req(req),
      .rdata(rdata), .rvalid(rvalid), .cell_select(cell_select),
      .sample_strobe(sample_strobe), .calibrating(calibrating),
      .internal_sensor_select(internal_sensor_select));
   frontend_model fe (.cell_select(cell_select), .cells(cells),
      .frontend_cell_output(cell_voltage_input));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // ----------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic report_and_stop();
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop
   task automatic hang();
      err_count++;
      $display("unexpected at %0t: wait ran out", $time);
      report_and_stop();
   endtask : hang
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge clk);
      req = '{a, d, 1'b1, 1'b0};
      @(negedge clk);
      req.wr = 1'b0;
   endtask : wr
   task automatic chk_rd(input logic [7:0] a, input logic [15:0] e);
      int k;
      @(negedge clk);
      req = '{a, 16'h0000, 1'b0, 1'b1};
      @(negedge clk);
      req.rd = 1'b0;
      for (k = 0; k < 4 && rvalid !== 1'b1; k++) @(negedge clk);
      if (rvalid !== 1'b1) hang();
      rd_val = rdata;
      check(rd_val, e);
   endtask : chk_rd
   // Waits past the fold so new samples land in the next period
   task automatic next_period();
      int k;
      for (k = 0; k < PER + 20 && sample_strobe !== 1'b1; k++) @(negedge clk);
      if (sample_strobe !== 1'b1) hang();
      repeat (16) @(negedge clk);
   endtask : next_period
   task automatic feed(input int n, input bit dis);
      int k, s;
      for (k = 0; k < n; k++) begin
         @(negedge clk);
         s = dis ? -30000 : (k < 2) ? filt - 1 + k : $random(seed) & 32'h3FF;
         sense_sample = 16'(s);
         sense_valid = 1'b1;
         if (s >= filt || -s >= filt) acc += s;
      end
      @(negedge clk);
      sense_valid = 1'b0;
   endtask : feed
   // ----------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------
   initial begin
      seed = 32'hfaaa;
      {err_count, comparisons, acc, rem_m} = '0;
      {rstn, sense_valid, sense_sample} = '0;
      {smb_clk_in, smb_data_in} = 2'b11;
      req = '0;
      filt = 16;
      for (i = 0; i < 4; i++) cells[i] = 16'h0C00 + 16'($random(seed) & 8'hFF);
      thermistor_input = 16'($random(seed)) & 16'h0FFF;
      internal_temp = 16'($random(seed)) & 16'h0FFF;
      sum = cells[0] + cells[1] + cells[2] + cells[3];
      repeat (6) @(negedge clk);
      rstn = 1'b1;
      chk_rd(FULL_CAP_ADDR, FCC_RESET);
      chk_rd(CFG_FILTER_ADDR, FILTER_RESET);
      chk_rd(REM_CAP_ADDR, 16'h0000);
      chk_rd(8'h55, 16'h0000);
      wr(CFG_FILTER_ADDR, 16'(filt));
      wr(CELL_ONE_ADDR, 16'hFFFF);
      wr(CFG_MISC_ADDR, 16'h0080);
      check({15'h0, internal_sensor_select}, 16'h0001);
      next_period();
      for (i = 0; i < 4; i++) chk_rd(8'(CELL_ONE_ADDR + i), cells[i]);
      chk_rd(TEMP_ADDR, internal_temp);
      wr(CFG_MISC_ADDR, 16'h0000);
      next_period();
      next_period();
      chk_rd(TEMP_ADDR, thermistor_input);
      chk_rd(VOLTAGE_ADDR, sum);
      chk_rd(CFG_FILTER_ADDR, 16'(filt));
      repeat (2) begin
         feed(40, 1'b0);
         next_period();
         units = acc / 1024;
         rem_m += units;
         acc -= units * 1024;
         chk_rd(REM_CAP_ADDR, rem_m[15:0]);
      end
      feed(20, 1'b1);
      next_period();
      chk_rd(REM_CAP_ADDR, 16'h0000);
      chk_rd(CURRENT_ADDR, 16'(-30000));
      // Only one line low must not count as an idle bus
      smb_clk_in = 1'b0;
      repeat (3 * CAL) @(negedge clk);
      check({15'h0, calibrating}, 16'h0000);
      smb_data_in = 1'b0;
      for (i = 0; i < 3 * CAL && calibrating !== 1'b1; i++) @(negedge clk);
      check({15'h0, calibrating}, 16'h0001);
      {smb_clk_in, smb_data_in} = 2'b11;
      repeat (80) @(negedge clk);
      report_and_stop();
   end
endmodule : coulomb_counter_tb
